//--- hdl/i2c_cfg_slave.v
`include "cfg_slave_regs.vh"
`default_nettype none

// Overview of operation
// [R1] data changes only while clock low
// [R2] start and stop seen while clock high
// [R3] master stops before every new start
// [R4] eight bits msb first, then ack
// [R5] nine pulses per byte, receiver pulls low
// [R6] address 1000_110 or 1000_111 by strap
// [R7] address captured at power-good rise only
// [R8] interface works only while power good
// [R9] control byte: address then direction bit
// [R10] wrong address leaves data line released
// [R11] register address byte zero or one acked
// [R12] single write committed at stop
// [R13] sequential write fills second register next
// [R14] read returns the selected register byte
// [R15] master nacks last byte then stops
// [R16] acked first byte followed by second register
// [R17] data line only pulled low or released
// [R18] slave only, clock always from master
// [R19] standard and fast mode bit rates
// [R20] margin register codes 12.5 mV steps
// [R21] config register holds frequency adjustment
// [R22] config register holds deadtime and overvoltage select
// [R23] registers zero at power-up and power loss
// [R24] low pin clears registers immediately
// [R25] bad register address and extra bytes nacked
module i2c_cfg_slave (
    input wire core_clk,
    input wire reset_n,
    input wire sclIn,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe,
    input wire powerGood,
    input wire addrStrap,
    input wire pinBelowReset,
    output wire [7:0] marginOffset,
    output wire [7:0] converterConfig,
    output reg [6:0] slaveAddress
);

    // bus states
    localparam [2:0] S_IDLE = 3'b000; // waiting for a start
    localparam [2:0] S_CTRL = 3'b001; // receiving the control byte
    localparam [2:0] S_REG = 3'b010; // receiving the register address
    localparam [2:0] S_DATA = 3'b011; // receiving data bytes
    localparam [2:0] S_ACK = 3'b100; // holding the ack low for pulse nine
    localparam [2:0] S_TX = 3'b101; // shifting a register byte out
    localparam [2:0] S_MACK = 3'b110; // master ack slot after a sent byte

    // synchronised pins
    wire sclSync; // clock line after two flops
    wire sdaSync; // data line after two flops
    wire pgSync; // power-good after two flops
    wire strapSync; // strap level after two flops
    wire clrSync; // low-pin comparator after two flops

    // edge history, taken from the synchroniser outputs only
    reg sclPrev; // clock line one cycle ago
    reg sdaPrev; // data line one cycle ago
    reg pgPrev; // power-good one cycle ago

    // protocol state
    reg [2:0] state; // current bus state
    reg [2:0] afterAck; // state entered when the ack pulse ends
    reg [2:0] bitCnt; // bit index within the byte
    reg [7:0] shiftReg; // receive and transmit shifter
    reg byteDone; // eighth bit seen, act on next falling edge
    reg ackWanted; // decision for the coming ack slot
    reg regPtr; // current register address
    reg [1:0] wrPtr; // register index for the next write byte
    reg masterAcked; // master pulled low in its ack slot

    // pending write bytes, committed only on a stop
    reg [7:0] pend0; // byte for the margin register
    reg [7:0] pend1; // byte for the config register
    reg pend0Valid; // pend0 holds new data
    reg pend1Valid; // pend1 holds new data
    reg commit0; // one-cycle load of the margin register
    reg commit1; // one-cycle load of the config register

    // edges and conditions
    wire sclRise;
    wire sclFall;
    wire startCond;
    wire stopCond;
    wire [7:0] rxByte;
    wire busActive;
    wire regClear;

    pin_sync #(.RESET_VAL(`LINE_IDLE)) syncScl (
        .clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(sclIn),
        .syncOut(sclSync)
    );

    pin_sync #(.RESET_VAL(`LINE_IDLE)) syncSda (
        .clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(sdaIn),
        .syncOut(sdaSync)
    );

    pin_sync #(.RESET_VAL(`PIN_IDLE)) syncPg (
        .clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(powerGood),
        .syncOut(pgSync)
    );

    pin_sync #(.RESET_VAL(`PIN_IDLE)) syncStrap (
        .clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(addrStrap),
        .syncOut(strapSync)
    );

    pin_sync #(.RESET_VAL(`PIN_IDLE)) syncClr (
        .clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(pinBelowReset),
        .syncOut(clrSync)
    );

    // clock edges found by sampling; the master owns the clock [R18]
    // 4 ns sampling leaves wide margin even at 400 kbit/s [R19]
    assign sclRise = sclSync & ~sclPrev;
    assign sclFall = ~sclSync & sclPrev;
    // data moving while clock high frames a transfer [R1]
    assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync; // [R2]
    assign stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync; // [R2]
    // byte as it stands once the eighth bit is sampled, msb first [R4]
    assign rxByte = {shiftReg[6:0], sdaSync};
    // the interface only lives while power is good [R8]
    assign busActive = pgSync;
    // power loss or the low pin clears the registers [R23] [R24]
    assign regClear = ~pgSync | clrSync;

    // edge history registers
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclPrev <= `LINE_IDLE;
            sdaPrev <= `LINE_IDLE;
            pgPrev <= `PIN_IDLE;
        end else begin
            sclPrev <= sclSync;
            sdaPrev <= sdaSync;
            pgPrev <= pgSync;
        end
    end

    // slave address latched once when power becomes good [R7]
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            slaveAddress <= {`SLAVE_ADDR_UPPER, 1'b0};
        end else if (pgSync & ~pgPrev) begin
            // strap to ground gives ...110, to supply gives ...111 [R6]
            slaveAddress <= {`SLAVE_ADDR_UPPER, strapSync};
        end
    end

    // the pad is open drain: the output level never leaves zero [R17]
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end

    // main protocol machine
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= S_IDLE;
            afterAck <= S_IDLE;
            bitCnt <= 3'h0;
            shiftReg <= 8'h00;
            byteDone <= 1'b0;
            ackWanted <= 1'b0;
            regPtr <= 1'b0;
            wrPtr <= 2'h0;
            masterAcked <= 1'b0;
            sdaOe <= 1'b0;
            pend0 <= `CFG_RESET_VALUE;
            pend1 <= `CFG_RESET_VALUE;
            pend0Valid <= 1'b0;
            pend1Valid <= 1'b0;
            commit0 <= 1'b0;
            commit1 <= 1'b0;
        end else begin
            // commits are single-cycle pulses
            commit0 <= 1'b0;
            commit1 <= 1'b0;
            if (!busActive) begin
                // below the power threshold: line released, nothing pending [R8]
                state <= S_IDLE;
                sdaOe <= 1'b0;
                byteDone <= 1'b0;
                pend0Valid <= 1'b0;
                pend1Valid <= 1'b0;
                regPtr <= 1'b0;
            end else if (stopCond) begin
                // transaction complete: apply the new settings now [R12] [R13]
                commit0 <= pend0Valid;
                commit1 <= pend1Valid;
                pend0Valid <= 1'b0;
                pend1Valid <= 1'b0;
                state <= S_IDLE;
                sdaOe <= 1'b0;
                byteDone <= 1'b0;
            end else if (startCond) begin
                // a start without a stop first drops unfinished writes [R3]
                pend0Valid <= 1'b0;
                pend1Valid <= 1'b0;
                state <= S_CTRL;
                bitCnt <= 3'h0;
                byteDone <= 1'b0;
                sdaOe <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: begin
                        // released line while waiting
                        sdaOe <= 1'b0;
                    end
                    S_CTRL, S_REG, S_DATA: begin
                        if (sclRise) begin
                            // sample while clock high, data stable then [R1] [R4]
                            shiftReg <= rxByte;
                            bitCnt <= bitCnt + 3'h1;
                            if (bitCnt == `BIT_LAST) begin
                                byteDone <= 1'b1;
                                ackWanted <= 1'b0;
                                afterAck <= S_IDLE;
                                if (state == S_CTRL) begin
                                    // seven address bits then direction [R9]
                                    if (rxByte[7:1] == slaveAddress) begin
                                        ackWanted <= 1'b1;
                                        afterAck <= (rxByte[`CTRL_DIR_BIT] == `DIR_READ) ? S_TX : S_REG;
                                    end
                                    // no match: ackWanted stays low, line stays released [R10]
                                end else if (state == S_REG) begin
                                    // only the two register addresses are acked [R11] [R25]
                                    if (rxByte == `REG_ADDR_MARGIN || rxByte == `REG_ADDR_CONFIG) begin
                                        ackWanted <= 1'b1;
                                        afterAck <= S_DATA;
                                        regPtr <= rxByte[0];
                                        wrPtr <= {1'b0, rxByte[0]};
                                    end
                                end else begin
                                    // data byte held until the stop [R12]
                                    if (wrPtr != `WPTR_END) begin
                                        ackWanted <= 1'b1;
                                        afterAck <= S_DATA;
                                        wrPtr <= wrPtr + 2'h1;
                                        if (wrPtr == 2'h0) begin
                                            pend0 <= rxByte;
                                            pend0Valid <= 1'b1;
                                        end else begin
                                            // config register byte: second of a sequential write, or first at address one [R13]
                                            pend1 <= rxByte;
                                            pend1Valid <= 1'b1;
                                        end
                                    end
                                    // beyond the second register: nacked, ignored [R25]
                                end
                            end
                        end else if (sclFall && byteDone) begin
                            // ninth pulse: pull low to ack, only after clock low [R5] [R1]
                            byteDone <= 1'b0;
                            if (ackWanted) begin
                                sdaOe <= 1'b1;
                                state <= S_ACK;
                            end else begin
                                sdaOe <= 1'b0;
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_ACK: begin
                        if (sclFall) begin
                            // ninth pulse over: release or present the first read bit
                            bitCnt <= 3'h0;
                            state <= afterAck;
                            if (afterAck == S_TX) begin
                                // read from the current register address [R14]
                                shiftReg <= regPtr ? converterConfig : marginOffset;
                                sdaOe <= regPtr ? ~converterConfig[7] : ~marginOffset[7];
                            end else begin
                                sdaOe <= 1'b0;
                            end
                        end
                    end
                    S_TX: begin
                        if (sclRise) begin
                            bitCnt <= bitCnt + 3'h1;
                            if (bitCnt == `BIT_LAST) begin
                                byteDone <= 1'b1;
                            end
                        end else if (sclFall) begin
                            if (byteDone) begin
                                // release for the master's ack slot [R5]
                                byteDone <= 1'b0;
                                sdaOe <= 1'b0;
                                state <= S_MACK;
                            end else begin
                                // next bit, msb first, low is pulled and high released [R4] [R17]
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                sdaOe <= ~shiftReg[6];
                            end
                        end
                    end
                    S_MACK: begin
                        if (sclRise) begin
                            masterAcked <= ~sdaSync;
                        end else if (sclFall) begin
                            if (masterAcked) begin
                                // acked byte: the second register follows [R16]
                                regPtr <= 1'b1;
                                bitCnt <= 3'h0;
                                shiftReg <= converterConfig;
                                sdaOe <= ~converterConfig[7];
                                state <= S_TX;
                            end else begin
                                // nack ends the read, wait for the stop [R15]
                                sdaOe <= 1'b0;
                                state <= S_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // margin offset register, low six bits are the step code [R20] [R23] [R24]
    conf_store #(.WIDTH(8), .RESET_VAL(`CFG_RESET_VALUE)) marginStore (
        .clk(core_clk),
        .reset_n(reset_n),
        .clear(regClear),
        .load(commit0),
        .din(pend0),
        .q(marginOffset)
    );

    // converter config register: deadtime, overvoltage and frequency fields [R21] [R22] [R23]
    conf_store #(.WIDTH(8), .RESET_VAL(`CFG_RESET_VALUE)) configStore (
        .clk(core_clk),
        .reset_n(reset_n),
        .clear(regClear),
        .load(commit1),
        .din(pend1),
        .q(converterConfig)
    );

endmodule // i2c_cfg_slave

`default_nettype wire

//--- hdl/cfg_slave_regs.vh
`ifndef CFG_SLAVE_REGS_VH
`define CFG_SLAVE_REGS_VH

// upper six bits of the 7-bit slave address, lowest bit comes from the strap
`define SLAVE_ADDR_UPPER 6'h23
// register address bytes
`define REG_ADDR_MARGIN 8'h00
`define REG_ADDR_CONFIG 8'h01
// reset value of both configuration registers
`define CFG_RESET_VALUE 8'h00
// margining code field: six bits, 12.5 mV per step, code zero is no offset
`define MARGIN_CODE_MSB 5
`define MARGIN_CODE_LSB 0
// index of the last bit of a byte, counted from zero, msb first
`define BIT_LAST 3'h7
// direction bit inside the control byte, and its read value
`define CTRL_DIR_BIT 0
`define DIR_READ 1'h1
// write pointer limit: two registers, index 2 is past the end
`define WPTR_END 2'h2
// synchroniser reset levels: bus lines idle high, other pins low
`define LINE_IDLE 1'h1
`define PIN_IDLE 1'h0

`endif

//--- hdl/pin_sync.v
`default_nettype none

// two-flop synchroniser for one asynchronous input
module pin_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk,
    input wire reset_n,
    input wire asyncIn,
    output reg syncOut
);

    reg firstStage; // metastable stage, read only by syncOut

    // second flop is the only reader of the first
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            firstStage <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            firstStage <= asyncIn;
            syncOut <= firstStage;
        end
    end

endmodule // pin_sync

`default_nettype wire

//--- hdl/conf_store.v
`default_nettype none

// one byte-wide configuration register with a clear that wins over a load
module conf_store #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire reset_n,
    input wire clear,
    input wire load,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] q
);

    // clear first: a power loss or pin reset must not be overridden by a late commit
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= RESET_VAL;
        end else if (clear) begin
            q <= RESET_VAL;
        end else if (load) begin
            q <= din;
        end
    end

endmodule // conf_store

`default_nettype wire

//--- sim/i2c_cfg_slave_chk.sv
`include "cfg_slave_regs.vh"
`default_nettype none
// watches the slave's ports only; every input mirrors a port of the design top
module i2c_cfg_slave_chk (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic powerGood,
    input wire logic addrStrap,
    input wire logic pinBelowReset,
    input wire logic [7:0] marginOffset,
    input wire logic [7:0] converterConfig,
    input wire logic [6:0] slaveAddress
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // five samples cover the two-flop synchroniser plus the clear itself
    sequence pinHeld; pinBelowReset [*5]; endsequence
    sequence powerLost; !powerGood [*5]; endsequence
    // long enough after power-good for the address latch to have fired
    sequence powerSettled; powerGood [*8]; endsequence
    // strap held still while the address is latched
    sequence strapLatched; $rose(powerGood) ##1 (powerGood && $stable(addrStrap)) [*6]; endsequence
    a_pad_never_high: assert property (!sdaOut)
        else $error("data pad value is high");
    a_pad_moves_low: assert property (!$stable(sdaOe) |-> !sclIn)
        else $error("data pad changed while clock high");
    a_off_released: assert property (powerLost |-> !sdaOe)
        else $error("data pad pulled while power is down");
    a_power_clear: assert property (powerLost |-> marginOffset == 8'h00 && converterConfig == 8'h00)
        else $error("registers not cleared by power loss");
    a_pin_clear: assert property (pinHeld |-> marginOffset == 8'h00 && converterConfig == 8'h00)
        else $error("registers not cleared by low pin");
    a_addr_fixed: assert property (powerSettled |-> $stable(slaveAddress))
        else $error("slave address moved while powered");
    a_addr_upper: assert property (slaveAddress[6:1] == `SLAVE_ADDR_UPPER)
        else $error("slave address upper bits wrong");
    a_addr_strap: assert property (strapLatched |-> slaveAddress[0] == addrStrap)
        else $error("slave address low bit differs from strap");
    // commits follow a stop, which happens with the clock high; clears give zero
    a_commit_clock_high: assert property (!$stable(marginOffset) || !$stable(converterConfig)
        |-> sclIn || (marginOffset == 8'h00 && converterConfig == 8'h00))
        else $error("register changed away from a stop");
endmodule // i2c_cfg_slave_chk
bind i2c_cfg_slave i2c_cfg_slave_chk u_chk (.core_clk(core_clk), .reset_n(reset_n), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .powerGood(powerGood), .addrStrap(addrStrap),
    .pinBelowReset(pinBelowReset), .marginOffset(marginOffset), .converterConfig(converterConfig),
    .slaveAddress(slaveAddress));
`default_nettype wire

//--- sim/i2c_master_model.sv
`default_nettype none
// bus master: owns the clock line, pulls data low through an open drain
module i2c_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic pullLow
);
    timeunit 1ns;
    timeprecision 100ps;
    // both lines idle high; the clock stands still outside frames
    initial begin
        scl = 1'b1;
        pullLow = 1'b0;
    end
    // changes land just after a core edge; three edges make a quarter link period
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // data falls while the clock is high
    task automatic start();
        pullLow = 1'b1;
        tick(3);
        scl = 1'b0;
        tick(3);
    endtask
    // one pulse: data set mid-low, line sampled late in the high phase
    task automatic pulse(input logic b, output logic r);
        pullLow = !b;
        tick(3);
        scl = 1'b1;
        tick(5);
        r = sda;
        tick(1);
        scl = 1'b0;
        tick(3);
    endtask
    // eight bits msb first, ninth pulse carries the slave's answer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) pulse(b[i], r);
        pulse(1'b1, r);
        ack = !r;
    endtask
    // line released for the data; the master answers on the ninth pulse
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
        pulse(!more, r);
    endtask
    // data rises while the clock is high; bus left idle long enough to commit
    task automatic stop();
        pullLow = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        pullLow = 1'b0;
        tick(9);
    endtask
endmodule // i2c_master_model
`default_nettype wire

//--- sim/i2c_slave_config_registers_bench.sv
`include "cfg_slave_regs.vh"
`default_nettype none
// top bench: master model on the wire, register model kept with plain arrays
module i2c_slave_config_registers_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk;
    logic reset_n;
    logic powerGood;
    logic addrStrap;
    logic pinBelowReset;
    logic scl;
    logic pullLow;
    logic sdaOut;
    logic sdaOe;
    logic [7:0] marginOffset;
    logic [7:0] converterConfig;
    logic [6:0] slaveAddress;
    // wired-and with a pull-up: either party pulling wins
    wire sda = !(pullLow || (sdaOe && !sdaOut));
    logic [7:0] mdl [2]; // expected register contents
    int ptr; // expected register pointer
    logic [6:0] expAddr; // expected slave address
    logic pgOn; // model's view of power
    int err_count;
    int num_checks;
    logic [31:0] seed = 32'h000082b5; // 33461
    i2c_cfg_slave u_dut (.core_clk(core_clk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .powerGood(powerGood), .addrStrap(addrStrap), .pinBelowReset(pinBelowReset),
        .marginOffset(marginOffset), .converterConfig(converterConfig), .slaveAddress(slaveAddress));
    i2c_master_model u_master (.clk(core_clk), .sda(sda), .scl(scl), .pullLow(pullLow));
    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // xorshift source, low byte used
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_regs();
        chk("margin offset", mdl[0], marginOffset);
        chk("converter config", mdl[1], converterConfig);
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    // write frame with n data bytes; acks and commit compared with the model
    task automatic wr(input logic [6:0] a, input logic [7:0] ra, input int n, input logic [23:0] dat);
        logic [4:0] got;
        logic [4:0] want;
        int p;
        got = 5'h00;
        want = 5'h00;
        p = ra;
        u_master.start();
        u_master.wbyte({a, 1'b0}, got[4]);
        u_master.wbyte(ra, got[3]);
        for (int i = 0; i < n; i++) u_master.wbyte(dat[23 - 8 * i -: 8], got[2 - i]);
        u_master.stop();
        // refused frames leave the pointer and registers alone
        if (pgOn && a == expAddr) begin
            want[4] = 1'b1;
            if (ra < 8'h02) begin
                want[3] = 1'b1;
                ptr = ra;
                for (int i = 0; i < n; i++) if (p < 2) begin
                    want[2 - i] = 1'b1;
                    mdl[p] = dat[23 - 8 * i -: 8];
                    p++;
                end
            end
        end
        chk("ack pattern", {3'h0, want}, {3'h0, got});
        chk_regs();
    endtask
    // read frame from the pointer; reading past the second register repeats it
    task automatic rd(input int n);
        logic a;
        logic [7:0] d;
        u_master.start();
        u_master.wbyte({expAddr, 1'b1}, a);
        chk("read ctrl ack", 8'h01, {7'h00, a});
        for (int i = 0; i < n; i++) begin
            u_master.rbyte(i < n - 1, d);
            chk("read data", mdl[(ptr + i > 1) ? 1 : ptr + i], d);
        end
        u_master.stop();
    endtask
    // power-good change with the strap set ahead and held through the latch
    task automatic power(input logic on, input logic strap);
        addrStrap = strap;
        u_master.tick(2);
        powerGood = on;
        pgOn = on;
        u_master.tick(10);
        if (on) begin
            expAddr = {`SLAVE_ADDR_UPPER, strap};
            chk("slave address", {1'b0, expAddr}, {1'b0, slaveAddress});
        end else begin
            mdl[0] = 8'h00;
            mdl[1] = 8'h00;
            ptr = 0;
        end
        chk_regs();
    endtask
    initial begin
        reset_n = 1'b0;
        powerGood = 1'b0;
        addrStrap = 1'b0;
        pinBelowReset = 1'b0;
        pgOn = 1'b0;
        ptr = 0;
        mdl[0] = 8'h00;
        mdl[1] = 8'h00;
        expAddr = {`SLAVE_ADDR_UPPER, 1'b0};
        repeat (4) @(posedge core_clk);
        #1 reset_n = 1'b1;
        chk_regs();
        power(1'b1, ^rnd());
        addrStrap = !addrStrap; // a strap change after the latch must be ignored
        for (int r = 0; r < 2; r++) wr(expAddr, r[7:0], 1, {rnd(), 16'h0000});
        note("single writes");
        wr(expAddr, 8'h00, 3, {rnd(), rnd(), rnd()});
        wr(expAddr, 8'h01, 2, {rnd(), rnd(), 8'h00});
        note("sequential writes");
        wr(expAddr, 8'h00, 0, 24'h000000);
        rd(3);
        wr(expAddr, 8'h01, 0, 24'h000000);
        rd(1);
        note("reads");
        wr(expAddr ^ 7'h01, 8'h00, 1, {rnd(), 16'h0000});
        wr(expAddr, 8'h02, 1, {rnd(), 16'h0000});
        wr(expAddr, 8'hff, 1, {rnd(), 16'h0000});
        chk("held address", {1'b0, expAddr}, {1'b0, slaveAddress});
        note("refusals");
        pinBelowReset = 1'b1;
        u_master.tick(8);
        mdl[0] = 8'h00;
        mdl[1] = 8'h00;
        chk_regs();
        pinBelowReset = 1'b0;
        wr(expAddr, 8'h00, 2, {rnd(), rnd(), 8'h00});
        note("pin clear");
        power(1'b0, addrStrap);
        wr(expAddr, 8'h00, 1, {rnd(), 16'h0000});
        power(1'b1, !expAddr[0]);
        wr(expAddr, 8'h01, 1, {rnd(), 16'h0000});
        rd(2);
        note("power cycle");
        finish_test();
    end
    // the whole run needs some 22 us; this cuts a hang well past that
    initial begin
        #200000;
        err_count++;
        $display("watchdog expired");
        finish_test();
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
endmodule // i2c_slave_config_registers_bench
`default_nettype wire
